/* hdl/slp_sleep_unit.sv */
// power-down instruction decode and execute, with sleep and watchdog wake
// assumes instr is stable across the first phase of each instruction cycle
// Function
// RULE1 - the power-down opcode is the single word with upper twelve bits zero and low nibble 0011.
// RULE2 - executing it clears the power-down flag.
// RULE3 - executing it sets the timeout flag.
// RULE4 - executing it clears the watchdog counter and its postscaler.
// RULE5 - after the flag updates the core sleeps until a wake-up event.
// RULE6 - while asleep the oscillator is stopped and no core phase runs.
// RULE7 - a watchdog wake-up from sleep clears the timeout flag.
// RULE8 - the instruction takes one word and one cycle: decode, no-op, process, sleep.
`timescale 1ns/1ns
module slp_sleep_unit
    import slp_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    // instruction fetch
    input  wire logic [15:0] instr,
    input  wire logic        instr_valid,
    // wake-up sources
    input  wire logic        wdt_timeout,
    input  wire logic        wake_evt,
    // status and control
    output logic             timeout_flag,
    output logic             powerdown_flag,
    output logic             wdt_clear,
    output logic             sleeping,
    output logic             osc_run,
    output logic [3:0]       q_phase
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        slp_state_t st;
        logic       to;
        logic       pwrdn;
        logic       wclr;
    } slp_unit_t;

    localparam slp_unit_t SLP_RST = '{st: SLP_ST_RUN, to: SLP_TO_RST,
                                     pwrdn: SLP_PWRDN_RST, wclr: 1'b0};

    slp_unit_t s_q;
    slp_unit_t s_d;
    slp_q_if   qif ();

    // ------------------------------------------------------------
    // phase divider
    // ------------------------------------------------------------
    slp_qphase u_qphase (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .qif     (qif.gen)
    );

    assign qif.run = (s_q.st != SLP_ST_SLEEP); // RULE6

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic is_sleep_op;
    assign is_sleep_op = instr_valid && (instr == SLP_OPC_SLEEP); // RULE1

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    always_comb begin
        s_d      = s_q;
        s_d.wclr = 1'b0;
        case (s_q.st)
            SLP_ST_RUN: begin
                if (qif.q[0] && is_sleep_op) begin
                    s_d.st = SLP_ST_EXEC; // RULE8
                end
            end
            SLP_ST_EXEC: begin
                if (qif.q[2]) begin
                    s_d.to   = 1'b1; // RULE3
                    s_d.pwrdn = 1'b0; // RULE2
                    s_d.wclr = 1'b1; // RULE4
                end
                if (qif.q[3]) begin
                    s_d.st = SLP_ST_SLEEP; // RULE5
                end
            end
            SLP_ST_SLEEP: begin
                if (wdt_timeout) begin
                    s_d.to = 1'b0; // RULE7
                    s_d.st = SLP_ST_RUN;
                end else if (wake_evt) begin
                    s_d.st = SLP_ST_RUN;
                end
            end
            default: begin
                s_d.st = SLP_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_q <= SLP_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign timeout_flag   = s_q.to;
    assign powerdown_flag = s_q.pwrdn;
    assign wdt_clear      = s_q.wclr;
    assign sleeping       = (s_q.st == SLP_ST_SLEEP);
    assign osc_run        = (s_q.st != SLP_ST_SLEEP);
    assign q_phase        = qif.q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    logic start;
    assign start = (s_q.st == SLP_ST_RUN) && qif.q[0] && is_sleep_op;

    property p_decode;
        start |=> (s_q.st == SLP_ST_EXEC) && qif.q[1];
    endproperty
    a_decode: assert property (p_decode) else $error("opcode not decoded"); // RULE1

    property p_pwrdn_clear;
        (s_q.st == SLP_ST_EXEC) && qif.q[2] |=> !powerdown_flag;
    endproperty
    a_pwrdn_clear: assert property (p_pwrdn_clear) else $error("power-down flag kept"); // RULE2

    property p_to_set;
        (s_q.st == SLP_ST_EXEC) && qif.q[2] |=> timeout_flag && !sleeping;
    endproperty
    a_to_set: assert property (p_to_set) else $error("timeout flag not set"); // RULE3

    property p_wdt_clr;
        (s_q.st == SLP_ST_EXEC) && qif.q[2] |=> wdt_clear ##1 !wdt_clear;
    endproperty
    a_wdt_clr: assert property (p_wdt_clr) else $error("watchdog clear not one pulse"); // RULE4

    property p_enter;
        (s_q.st == SLP_ST_EXEC) && qif.q[3] |=> sleeping;
    endproperty
    a_enter: assert property (p_enter) else $error("sleep not entered"); // RULE5

    property p_osc;
        sleeping |-> !osc_run && (q_phase == 4'h0);
    endproperty
    a_osc: assert property (p_osc) else $error("clock runs while asleep"); // RULE6

    property p_wake;
        sleeping && wdt_timeout |=> !timeout_flag && !sleeping && q_phase[0];
    endproperty
    a_wake: assert property (p_wake) else $error("watchdog wake wrong"); // RULE7

    property p_cycle;
        start |-> ##3 wdt_clear && q_phase[3] ##1 sleeping;
    endproperty
    a_cycle: assert property (p_cycle) else $error("instruction cycle wrong"); // RULE8

    property p_refuse;
        (s_q.st == SLP_ST_RUN) && !start |=> (s_q.st == SLP_ST_RUN);
    endproperty
    a_refuse: assert property (p_refuse) else $error("wrong word executed"); // RULE1

    property p_pwrdn_hold;
        !((s_q.st == SLP_ST_EXEC) && qif.q[2]) |=> $stable(powerdown_flag);
    endproperty
    a_pwrdn_hold: assert property (p_pwrdn_hold) else $error("power-down flag moved"); // RULE2

    property p_to_hold;
        !((s_q.st == SLP_ST_EXEC) && qif.q[2]) && !(sleeping && wdt_timeout)
            |=> $stable(timeout_flag);
    endproperty
    a_to_hold: assert property (p_to_hold) else $error("timeout flag moved"); // RULE3

    property p_wclr_only;
        wdt_clear |-> (s_q.st == SLP_ST_EXEC) && qif.q[3];
    endproperty
    a_wclr_only: assert property (p_wclr_only) else $error("stray watchdog clear"); // RULE4

    property p_stay;
        sleeping && !wdt_timeout && !wake_evt |=> sleeping && $stable(timeout_flag);
    endproperty
    a_stay: assert property (p_stay) else $error("left sleep without wake"); // RULE5

    property p_osc_run;
        osc_run != sleeping;
    endproperty
    a_osc_run: assert property (p_osc_run) else $error("oscillator enable wrong"); // RULE6

    property p_other_wake;
        sleeping && wake_evt && !wdt_timeout |=> timeout_flag && !sleeping && q_phase[0];
    endproperty
    a_other_wake: assert property (p_other_wake) else $error("other wake wrong"); // RULE7

    property p_phase;
        !sleeping |-> $onehot(q_phase);
    endproperty
    a_phase: assert property (p_phase) else $error("phase enables not one-hot"); // RULE8

    property p_exec_q;
        (s_q.st == SLP_ST_EXEC) |-> !q_phase[0] && !sleeping;
    endproperty
    a_exec_q: assert property (p_exec_q) else $error("execution spans a cycle"); // RULE8

    // ------------------------------------------------------------
    // coverage
    // ------------------------------------------------------------
    c_sleep:  cover property (start ##4 sleeping);
    c_wdt:    cover property (sleeping && wdt_timeout);
    c_wake:   cover property (sleeping && wake_evt && !wdt_timeout);
    c_refuse: cover property ((s_q.st == SLP_ST_RUN) && qif.q[0] && instr_valid && !is_sleep_op);
    c_rearm:  cover property (sleeping && wdt_timeout ##1 !sleeping ##[1:40] start);

endmodule

/* hdl/slp_pkg.sv */
// shared constants and types of the power-down instruction unit
// assumes one core clock; instruction cycle is four clock phases
package slp_pkg;

    // ------------------------------------------------------------
    // instruction encoding
    // ------------------------------------------------------------
    localparam logic [15:0] SLP_OPC_SLEEP = 16'h0003;

    // ------------------------------------------------------------
    // flag reset values
    // ------------------------------------------------------------
    localparam logic SLP_TO_RST = 1'h1;
    localparam logic SLP_PWRDN_RST = 1'h1;

    // ------------------------------------------------------------
    // phase timing
    // ------------------------------------------------------------
    localparam int          SLP_Q_PHASES = 4;
    localparam logic [1:0]  SLP_PH_RST   = 2'h0;
    localparam logic [1:0]  SLP_PH_LAST  = 2'h3;

    typedef enum logic [1:0] {
        SLP_ST_RUN,
        SLP_ST_EXEC,
        SLP_ST_SLEEP
    } slp_state_t;

endpackage

/* hdl/slp_q_if.sv */
// phase-enable carrier between the phase divider and the decoder
// assumes both ends on clk_sys
`timescale 1ns/1ns
interface slp_q_if;
    logic       run;
    logic [3:0] q;

    modport gen (input run, output q);
    modport use_q (output run, input q);
endinterface

/* hdl/slp_qphase.sv */
// four-phase enable divider for the instruction cycle
// assumes run drops while the core sleeps; restarts at the first phase
`timescale 1ns/1ns
module slp_qphase
    import slp_pkg::*;
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rstn,
    // phase enables
    slp_q_if.gen      qif
);

    typedef struct packed {
        logic [1:0] ph;
    } slp_ph_t;

    slp_ph_t s_q;
    slp_ph_t s_d;

    always_comb begin
        s_d = s_q;
        if (qif.run) begin
            s_d.ph = (s_q.ph == SLP_PH_LAST) ? SLP_PH_RST : s_q.ph + 2'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_q.ph <= SLP_PH_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // one-hot enable, gated off while stopped
    always_comb begin
        qif.q = '0;
        if (qif.run) begin
            qif.q[s_q.ph] = 1'b1;
        end
    end

endmodule

/* tb/tb_top.sv */
// bench for the power-down instruction unit, driving all ports itself
// assumes slp_pkg and the unit are compiled first; 25 MHz clock
`timescale 1ns/1ns
module tb_top
    import slp_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        clk_sys, rstn, instr_valid, wdt_timeout, wake_evt;
    logic [15:0] instr;
    logic        timeout_flag, powerdown_flag, wdt_clear, sleeping, osc_run;
    logic [3:0]  q_phase;
    int          mismatches = 0;
    int          checks     = 0;

    slp_sleep_unit dut_u (.clk_sys(clk_sys), .rstn(rstn), .instr(instr),
        .instr_valid(instr_valid), .wdt_timeout(wdt_timeout), .wake_evt(wake_evt),
        .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag),
        .wdt_clear(wdt_clear), .sleeping(sleeping), .osc_run(osc_run), .q_phase(q_phase));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // present a word in the cycle after phase tgt is seen
    task automatic issue(input logic [15:0] op, input logic [3:0] tgt, input logic v);
        int n;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (q_phase !== tgt && n < 20);
        if (q_phase !== tgt) begin
            mismatches++;
            conclude();
        end
        @(posedge clk_sys);
        instr       <= op;
        instr_valid <= v;
        @(posedge clk_sys);
        instr_valid <= 1'b0;
        instr       <= ~op;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic refuse(input logic [15:0] op, input logic [3:0] tgt, input logic v);
        issue(op, tgt, v);
        repeat (4) begin
            @(negedge clk_sys);
            chk({wdt_clear, sleeping, osc_run}, 3'h1);
        end
    endtask

    task automatic go_sleep(input logic pd0);
        issue(SLP_OPC_SLEEP, 4'h8, 1'b1);
        repeat (2) @(negedge clk_sys);
        chk({wdt_clear, powerdown_flag, osc_run}, {1'b0, pd0, 1'b1});
        @(negedge clk_sys);
        chk({wdt_clear, timeout_flag, powerdown_flag}, 3'h6);
        @(negedge clk_sys);
        chk({wdt_clear, sleeping, osc_run, q_phase}, 7'h20);
    endtask

    task automatic wake(input logic w, input logic e, input logic tf);
        repeat (3) begin
            @(negedge clk_sys);
            chk({sleeping, osc_run, q_phase}, 6'h20);
        end
        @(posedge clk_sys);
        wdt_timeout <= w;
        wake_evt    <= e;
        @(posedge clk_sys);
        wdt_timeout <= 1'b0;
        wake_evt    <= 1'b0;
        @(negedge clk_sys);
        chk({sleeping, osc_run, q_phase, powerdown_flag}, 7'h22);
        chk(timeout_flag, tf);
    endtask

    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    initial begin
        #200000;
        mismatches++;
        conclude();
    end

    initial begin
        rstn        = 1'b0;
        instr       = 16'h0000;
        instr_valid = 1'b0;
        wdt_timeout = 1'b0;
        wake_evt    = 1'b0;
        repeat (6) @(posedge clk_sys);
        chk({timeout_flag, powerdown_flag, wdt_clear, sleeping, osc_run, q_phase}, 9'h191);
        rstn <= 1'b1;
        refuse(16'h0013, 4'h8, 1'b1);
        refuse(16'h1003, 4'h8, 1'b1);
        refuse(16'h0002, 4'h8, 1'b1);
        refuse(SLP_OPC_SLEEP, 4'h8, 1'b0);
        refuse(SLP_OPC_SLEEP, 4'h1, 1'b1);
        go_sleep(1'b1);
        wake(1'b1, 1'b1, 1'b0);
        @(posedge clk_sys);
        wdt_timeout <= 1'b1;
        @(posedge clk_sys);
        wdt_timeout <= 1'b0;
        repeat (2) @(negedge clk_sys);
        chk({timeout_flag, sleeping}, 2'h0);
        go_sleep(1'b0);
        wake(1'b0, 1'b1, 1'b1);
        conclude();
    end
endmodule
